// ---- mscr_pkg.sv ----
// package: register map, fields and types for the flash write/erase register block
package mscr_pkg;
  localparam logic [7:0]  ADDR_PAGE_BUF   = 8'h10;
  localparam logic [7:0]  ADDR_WDATA      = 8'h18;
  localparam logic [7:0]  ADDR_STATUS     = 8'h1c;
  localparam logic [7:0]  ADDR_IFLAG      = 8'h30;
  localparam logic [7:0]  ADDR_IFLAG_SET  = 8'h34;
  localparam logic [7:0]  ADDR_IFLAG_CLR  = 8'h38;
  localparam logic [7:0]  ADDR_IENABLE    = 8'h3c;
  localparam logic [7:0]  ADDR_LOCK       = 8'h40;
  localparam logic [7:0]  ADDR_CACHE_CMD  = 8'h44;
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_WRITE_CMD  = 8'h0c;

  localparam logic [15:0] LOCK_UNLOCK_KEY = 16'h1b71;
  localparam logic [31:0] PAGE_BUF_RST    = 32'h0000_0000;
  localparam logic [31:0] WDATA_RST       = 32'h0000_0000;
  localparam int          NFLAGS          = 6;
  localparam logic [5:0]  IFLAG_RST       = 6'h00;

  // interrupt flag positions
  localparam int IF_ERASE = 0;
  localparam int IF_WRITE = 1;
  localparam int IF_HITS  = 2;
  localparam int IF_MISS  = 3;
  localparam int IF_PWRUP = 4;
  localparam int IF_PAR   = 5;

  // status positions
  localparam int ST_BUSY    = 0;
  localparam int ST_LOCKED  = 1;
  localparam int ST_INVADR  = 2;
  localparam int ST_WREADY  = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_ABORTED = 5;
  localparam int ST_RUNNING = 6;

  // write command, control and cache command positions
  localparam int WC_LOAD_ADDR = 0;
  localparam int WC_ERASE_PG  = 1;
  localparam int WC_WRITE_ONE = 3;
  localparam int WC_WRITE_TRG = 4;
  localparam int CTRL_RDCLR   = 3;
  localparam int CC_START     = 1;
  localparam int CC_STOP      = 2;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mscr_bus_req_t;

  typedef struct packed {
    logic        load_addr;
    logic        erase_page;
    logic        write_once;
    logic        write_trig;
    logic        wdata_wr;
    logic        start_counters;
    logic        stop_counters;
  } mscr_cmd_t;

  // events reported by the write controller, cache and flash behind the block
  typedef struct packed {
    logic        busy;
    logic        wdata_consumed;
    logic        addr_invalid;
    logic        access_violation;
    logic        access_ok;
    logic        erase_abort_irq;
    logic        word_timeout;
    logic        write_done;
    logic        erase_done;
    logic        hits_overflow;
    logic        misses_overflow;
    logic        counter_at_max;
    logic        power_up_done;
    logic        parity_error;
  } mscr_evt_t;

  typedef struct packed {
    logic [1:0]        rst_sync;
    logic [31:0]       page_buf;
    logic [31:0]       target_addr;
    logic [31:0]       wdata;
    logic              wready;
    logic              running;
    logic              aborted;
    logic              timeout;
    logic              invalid_address;
    logic              locked_acc;
    logic [NFLAGS-1:0] iflag;
    logic [NFLAGS-1:0] ienable;
    logic              cfg_locked;
    logic              read_clear;
    logic [31:0]       rdata;
    mscr_cmd_t         cmd;
  } mscr_state_t;
endpackage

// ---- mscr_regs.sv ----
// register block of the flash write/erase controller
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

module mscr_regs (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire mscr_pkg::mscr_bus_req_t bus_i,
  output logic [31:0]               rdata_o,
  input  wire mscr_pkg::mscr_evt_t  evt_i,
  output mscr_pkg::mscr_cmd_t       cmd_o,
  output logic [31:0]               target_addr_o,
  output logic [31:0]               wdata_o,
  output logic                      irq_o
);
  logic                 rst_b;
  mscr_pkg::mscr_state_t s_q;
  mscr_pkg::mscr_state_t s_d;
  logic                 rst_sync_q0;
  logic                 rst_sync_q1;

  // reset release through two flops, kept outside the state struct
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q0 <= 1'b0;
      rst_sync_q1 <= 1'b0;
    end else begin
      rst_sync_q0 <= 1'b1;
      rst_sync_q1 <= rst_sync_q0;
    end
  end
  assign rst_b = rst_sync_q1;

  logic       wr_page;
  logic       wr_wdata;
  logic       wr_ifs;
  logic       wr_ifc;
  logic       wr_ien;
  logic       wr_lock;
  logic       wr_ctrl;
  logic       wr_wcmd;
  logic       wr_ccmd;
  logic       rd_ifc_clear;
  logic [5:0] hw_set;

  always_comb begin
    wr_page  = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_PAGE_BUF);
    wr_wdata = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_WDATA);
    wr_ifs   = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_IFLAG_SET);
    wr_ifc   = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_IFLAG_CLR);
    wr_ien   = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_IENABLE);
    wr_lock  = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_LOCK);
    // control and write command registers only accept writes while unlocked; cache command writes are not gated
    wr_ctrl  = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_CTRL) && !s_q.cfg_locked;
    wr_wcmd  = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_WRITE_CMD) && !s_q.cfg_locked;
    wr_ccmd  = bus_i.wr && (bus_i.addr == mscr_pkg::ADDR_CACHE_CMD);
    rd_ifc_clear = bus_i.rd && (bus_i.addr == mscr_pkg::ADDR_IFLAG_CLR) && s_q.read_clear;
    hw_set = '0;
    hw_set[mscr_pkg::IF_ERASE] = evt_i.erase_done;
    hw_set[mscr_pkg::IF_WRITE] = evt_i.write_done;
    hw_set[mscr_pkg::IF_HITS]  = evt_i.hits_overflow;
    hw_set[mscr_pkg::IF_MISS]  = evt_i.misses_overflow;
    hw_set[mscr_pkg::IF_PWRUP] = evt_i.power_up_done;
    hw_set[mscr_pkg::IF_PAR]   = evt_i.parity_error;
  end

  always_comb begin
    s_d = s_q;
    s_d.rst_sync = '0;
    s_d.cmd = '0;
    s_d.rdata = 32'h0000_0000;

    if (wr_page) begin
      s_d.page_buf = bus_i.wdata;
    end
    // erase and write commands are dropped while an operation runs
    if (wr_wcmd && !evt_i.busy) begin
      s_d.cmd.load_addr  = bus_i.wdata[mscr_pkg::WC_LOAD_ADDR];
      s_d.cmd.erase_page = bus_i.wdata[mscr_pkg::WC_ERASE_PG];
      s_d.cmd.write_once = bus_i.wdata[mscr_pkg::WC_WRITE_ONE];
      s_d.cmd.write_trig = bus_i.wdata[mscr_pkg::WC_WRITE_TRG];
      if (bus_i.wdata[mscr_pkg::WC_LOAD_ADDR]) begin
        s_d.target_addr = s_q.page_buf;
      end
    end

    // ready: consume sets, software write clears; consume wins if both
    if (wr_wdata) begin
      s_d.wdata = bus_i.wdata;
      s_d.wready = 1'b0;
      s_d.cmd.wdata_wr = 1'b1;
    end
    if (evt_i.wdata_consumed) begin
      s_d.wready = 1'b1;
    end

    // timeout clear by command, but a new timeout event wins
    if (wr_wcmd && !evt_i.busy && (bus_i.wdata[mscr_pkg::WC_ERASE_PG] ||
        bus_i.wdata[mscr_pkg::WC_WRITE_TRG] || bus_i.wdata[mscr_pkg::WC_WRITE_ONE])) begin
      s_d.timeout = 1'b0;
    end
    if (evt_i.word_timeout) begin
      s_d.timeout = 1'b1;
    end
    if (evt_i.erase_abort_irq) begin
      s_d.aborted = 1'b1;
    end
    if (evt_i.addr_invalid) begin
      s_d.invalid_address = 1'b1;
    end
    // locked tracks the last operation outcome
    if (evt_i.access_ok) begin
      s_d.locked_acc = 1'b0;
    end
    if (evt_i.access_violation) begin
      s_d.locked_acc = 1'b1;
    end

    // counters: stop or reaching maximum ends the run
    if (wr_ccmd && bus_i.wdata[mscr_pkg::CC_START]) begin
      s_d.running = 1'b1;
      s_d.cmd.start_counters = 1'b1;
    end
    if (wr_ccmd && bus_i.wdata[mscr_pkg::CC_STOP]) begin
      s_d.running = 1'b0;
      s_d.cmd.stop_counters = 1'b1;
    end
    if (evt_i.counter_at_max) begin
      s_d.running = 1'b0;
    end

    if (wr_ctrl) begin
      s_d.read_clear = bus_i.wdata[mscr_pkg::CTRL_RDCLR];
    end
    if (wr_lock) begin
      s_d.cfg_locked = (bus_i.wdata[15:0] != mscr_pkg::LOCK_UNLOCK_KEY);
    end
    if (wr_ien) begin
      s_d.ienable = bus_i.wdata[mscr_pkg::NFLAGS-1:0];
    end

    // flags: clears first, then sets so a same-cycle event is kept
    if (wr_ifc) begin
      s_d.iflag = s_d.iflag & ~bus_i.wdata[mscr_pkg::NFLAGS-1:0];
    end
    if (rd_ifc_clear) begin
      s_d.iflag = s_d.iflag & ~s_q.iflag;
    end
    if (wr_ifs) begin
      s_d.iflag = s_d.iflag | bus_i.wdata[mscr_pkg::NFLAGS-1:0];
    end
    s_d.iflag = s_d.iflag | hw_set;

    if (bus_i.rd) begin
      case (bus_i.addr)
        mscr_pkg::ADDR_PAGE_BUF: s_d.rdata = s_q.page_buf;
        mscr_pkg::ADDR_WDATA:    s_d.rdata = s_q.wdata;
        mscr_pkg::ADDR_STATUS: begin
          s_d.rdata[mscr_pkg::ST_BUSY]    = evt_i.busy;
          s_d.rdata[mscr_pkg::ST_LOCKED]  = s_q.locked_acc;
          s_d.rdata[mscr_pkg::ST_INVADR]  = s_q.invalid_address;
          s_d.rdata[mscr_pkg::ST_WREADY]  = s_q.wready;
          s_d.rdata[mscr_pkg::ST_TIMEOUT] = s_q.timeout;
          s_d.rdata[mscr_pkg::ST_ABORTED] = s_q.aborted;
          s_d.rdata[mscr_pkg::ST_RUNNING] = s_q.running;
        end
        mscr_pkg::ADDR_IFLAG:   s_d.rdata[mscr_pkg::NFLAGS-1:0] = s_q.iflag;
        // without the option this reads zero and changes nothing
        mscr_pkg::ADDR_IFLAG_CLR: begin
          if (s_q.read_clear) begin
            s_d.rdata[mscr_pkg::NFLAGS-1:0] = s_q.iflag;
          end
        end
        mscr_pkg::ADDR_IENABLE: s_d.rdata[mscr_pkg::NFLAGS-1:0] = s_q.ienable;
        mscr_pkg::ADDR_LOCK:    s_d.rdata[0] = s_q.cfg_locked;
        mscr_pkg::ADDR_CTRL:    s_d.rdata[mscr_pkg::CTRL_RDCLR] = s_q.read_clear;
        default:                s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.page_buf <= mscr_pkg::PAGE_BUF_RST;
      s_q.wdata <= mscr_pkg::WDATA_RST;
      s_q.wready <= 1'b1;
      s_q.iflag <= mscr_pkg::IFLAG_RST;
      s_q.cfg_locked <= 1'b0;
      s_q.read_clear <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o       = s_q.rdata;
  assign cmd_o         = s_q.cmd;
  assign target_addr_o = s_q.target_addr;
  assign wdata_o       = s_q.wdata;
  assign irq_o         = |(s_q.iflag & s_q.ienable);
endmodule // mscr_regs

// ---- mscr_regs_asserts.sv ----
// checker: port-level properties of the flash write/erase register block
`timescale 1ns/1ps
module mscr_regs_asserts (
  input wire logic                    clk_i,
  input wire logic                    rst_b_i,
  input wire mscr_pkg::mscr_bus_req_t bus_i,
  input wire logic [31:0]             rdata_o,
  input wire mscr_pkg::mscr_evt_t     evt_i,
  input wire mscr_pkg::mscr_cmd_t     cmd_o,
  input wire logic [31:0]             target_addr_o,
  input wire logic [31:0]             wdata_o,
  input wire logic                    irq_o
);
  logic [31:0] pb_q;
  logic [5:0]  ien_q;
  // shadows of what software last wrote, so outputs can be tied to a cause
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pb_q  <= '0;
      ien_q <= '0;
    end else if (bus_i.wr && bus_i.addr == 8'h10) begin
      pb_q <= bus_i.wdata;
    end else if (bus_i.wr && bus_i.addr == 8'h3c) begin
      ien_q <= bus_i.wdata[5:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_key_wr; bus_i.wr && bus_i.addr == 8'h40 && bus_i.wdata[15:0] == 16'h1b71; endsequence
  sequence s_bad_wr; bus_i.wr && bus_i.addr == 8'h40 && bus_i.wdata[15:0] != 16'h1b71; endsequence
  sequence s_lock_rd; !bus_i.wr ##1 bus_i.rd && bus_i.addr == 8'h40; endsequence
  load_copy_a: assert property (cmd_o.load_addr |-> target_addr_o == $past(pb_q))
    else $error("target address differs from page buffer");
  word_take_a: assert property (bus_i.wr && bus_i.addr == 8'h18 |=> cmd_o.wdata_wr && wdata_o == $past(bus_i.wdata))
    else $error("write data word not taken");
  busy_show_a: assert property (bus_i.rd && bus_i.addr == 8'h1c && $stable(evt_i.busy) |=> rdata_o[0] == $past(evt_i.busy))
    else $error("busy not shown in status");
  busy_block_a: assert property (bus_i.wr && bus_i.addr == 8'h0c && evt_i.busy |=> !cmd_o.erase_page && !cmd_o.load_addr)
    else $error("command accepted while busy");
  set_irq_a: assert property (bus_i.wr && bus_i.addr == 8'h34 && |(bus_i.wdata[5:0] & ien_q) |=> irq_o)
    else $error("enabled flag set without request");
  no_enable_a: assert property (ien_q == 6'h00 && $past(ien_q) == 6'h00 |-> !irq_o)
    else $error("request with all enables clear");
  lock_on_a: assert property (s_bad_wr ##1 s_lock_rd |=> rdata_o == 32'h1)
    else $error("lock not reported engaged");
  lock_off_a: assert property (s_key_wr ##1 s_lock_rd |=> rdata_o == 32'h0)
    else $error("key did not unlock");
  stop_cause_a: assert property (cmd_o.stop_counters |-> $past(bus_i.wr && bus_i.addr == 8'h44 && bus_i.wdata[2]))
    else $error("stop pulse without stop write");
  idle_zero_a: assert property (!bus_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside read answer");
  wo_read_a: assert property (bus_i.rd && bus_i.addr == 8'h44 |=> rdata_o == 32'h0)
    else $error("cache command read not zero");
endmodule // mscr_regs_asserts

bind mscr_regs mscr_regs_asserts i_mscr_regs_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .evt_i(evt_i), .cmd_o(cmd_o),
  .target_addr_o(target_addr_o), .wdata_o(wdata_o), .irq_o(irq_o));

// ---- tb_top.sv ----
// testbench: scenario tasks for the flash write/erase register block
`timescale 1ns/1ps
module tb_top;
  logic                    clk_i;
  logic                    rst_b_i;
  mscr_pkg::mscr_bus_req_t bus;
  mscr_pkg::mscr_evt_t     evt;
  mscr_pkg::mscr_cmd_t     cmd;
  logic [31:0]             rdata;
  logic [31:0]             taddr;
  logic [31:0]             wdata;
  logic                    irq;
  int                      n_fail;
  int                      checked;
  mscr_regs i_mscr_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus), .rdata_o(rdata),
    .evt_i(evt), .cmd_o(cmd), .target_addr_o(taddr), .wdata_o(wdata), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one bus cycle, then an idle cycle so strobes never merge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    bus <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), rdata, exp);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_i);
    evt[b] <= 1'b1;
    @(posedge clk_i);
    evt[b] <= 1'b0;
  endtask
  task automatic t_status();
    logic [31:0] cw [3] = '{32'h2, 32'h8, 32'h10};
    logic [31:0] cx [3] = '{32'h20, 32'h10, 32'h8};
    pulse(11);
    rd(8'h1c, 32'hc);
    pulse(10);
    rd(8'h1c, 32'he);
    pulse(9);
    rd(8'h1c, 32'hc);
    pulse(8);
    rd(8'h1c, 32'h2c);
    for (int k = 0; k < 3; k++) begin
      pulse(7);
      rd(8'h1c, 32'h3c);
      acc(1'b1, 8'h0c, cw[k]);
      chk("command", {25'h0, cmd}, cx[k]);
      rd(8'h1c, 32'h2c);
    end
    acc(1'b1, 8'h44, 32'h2);
    chk("start", {25'h0, cmd}, 32'h2);
    rd(8'h1c, 32'h6c);
    pulse(2);
    rd(8'h1c, 32'h2c);
    acc(1'b1, 8'h44, 32'h4);
    chk("stop", {25'h0, cmd}, 32'h1);
    @(posedge clk_i);
    #1;
    chk("stop end", {25'h0, cmd}, 32'h0);
  endtask
  task automatic t_flags();
    int fb [6] = '{5, 6, 4, 3, 1, 0};
    for (int i = 0; i < 6; i++) begin
      pulse(fb[i]);
      rd(8'h30, (32'h2 << i) - 32'h1);
    end
    acc(1'b1, 8'h38, 32'hffff_ffff);
    rd(8'h30, 32'h0);
    acc(1'b1, 8'h3c, 32'h4);
    chk("irq", {31'h0, irq}, 32'h0);
    acc(1'b1, 8'h34, 32'hffff_ffd5);
    rd(8'h30, 32'h15);
    chk("irq", {31'h0, irq}, 32'h1);
    acc(1'b1, 8'h3c, 32'hffff_ffe8);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(8'h3c, 32'h28);
    rd(8'h38, 32'h0);
    rd(8'h30, 32'h15);
    acc(1'b1, 8'h00, 32'h8);
    rd(8'h38, 32'h15);
    rd(8'h30, 32'h0);
    acc(1'b1, 8'h34, 32'h1);
    acc(1'b1, 8'h38, 32'h3e);
    rd(8'h30, 32'h1);
  endtask
  task automatic t_lock();
    acc(1'b1, 8'h40, 32'h0001_1b70);
    rd(8'h40, 32'h1);
    acc(1'b1, 8'h10, 32'hcafe_0000);
    acc(1'b1, 8'h0c, 32'h1);
    chk("locked cmd", {25'h0, cmd}, 32'h0);
    acc(1'b1, 8'h40, 32'hffff_1b71);
    rd(8'h40, 32'h0);
    acc(1'b1, 8'h0c, 32'h1);
    chk("target", taddr, 32'hcafe_0000);
    @(posedge clk_i);
    evt.busy <= 1'b1;
    rd(8'h1c, 32'h2d);
    acc(1'b1, 8'h0c, 32'h2);
    chk("busy cmd", {25'h0, cmd}, 32'h0);
    @(posedge clk_i);
    evt.busy <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst_b_i = 1'b0;
    bus = '0;
    evt = '0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int a = 0; a < 8'h48; a += 4) rd(8'(a), (a == 8'h1c) ? 32'h8 : 32'h0);
    acc(1'b1, 8'h10, 32'h1234_5678);
    acc(1'b1, 8'h0c, 32'h1);
    chk("load pulse", {25'h0, cmd}, 32'h40);
    chk("target", taddr, 32'h1234_5678);
    acc(1'b1, 8'h18, 32'ha5a5_0f0f);
    chk("word pulse", {25'h0, cmd}, 32'h4);
    chk("word", wdata, 32'ha5a5_0f0f);
    rd(8'h1c, 32'h0);
    pulse(12);
    rd(8'h1c, 32'h8);
    t_status();
    t_flags();
    t_lock();
    close_out();
  end
  initial begin
    #500_000;
    n_fail++;
    close_out();
  end
endmodule // tb_top
